// >>> design/dac_cmd_pkg.sv
// ============================================================
// Shared constants for the dual converter command front end.
// ============================================================
package dac_cmd_pkg;

  // ==========================================================
  // Word layout.
  // ==========================================================
  localparam int WORD_BITS = 24;      // Bits in one command word.
  localparam int CODE_BITS = 12;      // Bits in one channel code.
  localparam int CMD_MSB = 23;        // Top bit of the command field.
  localparam int CMD_LSB = 20;        // Bottom bit of the command field.
  localparam int SEL_B_BIT = 19;      // Channel B select bit.
  localparam int SEL_A_BIT = 16;      // Channel A select bit.
  localparam int CODE_MSB = 15;       // Top bit of the channel code.
  localparam int CODE_LSB = 4;        // Bottom bit of the channel code.
  localparam int PWR_B_MSB = 7;       // Channel B power field, high bit.
  localparam int PWR_B_LSB = 6;       // Channel B power field, low bit.
  localparam int PWR_A_MSB = 1;       // Channel A power field, high bit.
  localparam int PWR_A_LSB = 0;       // Channel A power field, low bit.
  localparam int MASK_A_BIT = 0;      // Strobe mask bit for channel A.
  localparam int MASK_B_BIT = 3;      // Strobe mask bit for channel B.
  localparam int REF_OFF_BIT = 0;     // Set to switch the reference off.
  localparam int LAST_BYTE = 2;       // Index of the final data byte.

  // ==========================================================
  // Bus address.
  // ==========================================================
  localparam logic [4:0] ADDR_FIXED = 5'h03;  // Upper address bits.

  // ==========================================================
  // Commands.
  // ==========================================================
  localparam logic [3:0] CMD_NOP = 4'h0;          // Do nothing.
  localparam logic [3:0] CMD_WRITE = 4'h1;        // Load input register.
  localparam logic [3:0] CMD_UPDATE = 4'h2;       // Input to DAC register.
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3; // Load both registers.
  localparam logic [3:0] CMD_POWER = 4'h4;        // Power control.
  localparam logic [3:0] CMD_MASK = 4'h5;         // Load strobe mask.
  localparam logic [3:0] CMD_RESET = 4'h6;        // Software reset.
  localparam logic [3:0] CMD_REF = 4'h7;          // Reference setup.

  // ==========================================================
  // Values after reset.
  // ==========================================================
  localparam logic [11:0] RESET_CODE = 12'h000;   // Zero scale.
  localparam logic [3:0] RESET_POWER = 4'h0;      // Both channels normal.
  localparam logic [1:0] RESET_MASK = 2'h0;       // No channel masked.
  localparam logic [23:0] RESET_WORD = 24'h00_0000; // Empty shifter.
  localparam logic [5:0] PIN_IDLE = 6'h38; // Idle pins: bus and strobe high.

  // Bus receiver states.
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_DATA, S_DATA_ACK
  } bus_state_t;

endpackage

// >>> design/pin_sync.sv
`timescale 1ns/1ps
// ============================================================
// Two-flop synchroniser for pins from outside the clock domain.
// ============================================================
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0 // Levels held during reset.
) (
  input wire logic clock,              // System clock.
  input wire logic resetn,             // Asynchronous reset, active low.
  input wire logic clk_en,             // Freezes the flops while low.
  input wire logic [WIDTH-1:0] din,    // Raw pin levels.
  output logic [WIDTH-1:0] dout        // Synchronised levels.
);

  logic [WIDTH-1:0] meta; // First stage, read only by the second.

  // The first stage may go metastable; only the second stage reads it.
  // Reset holds the idle pin levels so no false edge follows reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else if (clk_en) begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// >>> design/dual_dac_i2c_command_decoder.sv
`timescale 1ns/1ps
// Operation
// RULE_01: Each write is one 24-bit word, MSB first.
// RULE_02: Bits 23..20 hold the command.
// RULE_03: Bit 19 selects B, bit 16 selects A.
// RULE_04: Bits 15..4 are the code; low four ignored.
// RULE_05: Bits enter shifter on 24 SCL falling edges.
// RULE_06: Command applies to A, B or both.
// RULE_07: Decode nop, power, mask, reset, reference, reserved.
// RULE_08: Command 1 loads input registers of selected channels.
// RULE_09: Low unmasked strobe makes input register transparent.
// RULE_10: Command 2 copies input into DAC register.
// RULE_11: Command 3 loads input and DAC registers.
// RULE_12: Code is unsigned straight binary, 0 to 4095.
// RULE_13: Gain pin low gives gain 1, high 2.
// RULE_14: Reference on at reset; off only by software.
// RULE_15: Power-on reset sets known register state.
// RULE_16: Works as slave at 100 and 400 kHz.
// RULE_17: Ignore ten-bit and general-call addressing.
// RULE_18: Address is 00011 plus two pin bits.
// RULE_19: Master sends address, command, high, low, stop.
// RULE_20: Reserved commands and empty selects change nothing.
// RULE_21: Act only after 24 bits acknowledged; stop discards.
module dual_dac_i2c_command_decoder (
  input wire logic clock,              // System clock, 250 MHz.
  input wire logic resetn,             // Asynchronous reset, active low.
  input wire logic clk_en,             // Freezes all state while low.
  input wire logic scl_in,             // Serial clock pin level.
  input wire logic sda_in,             // Serial data pin level.
  input wire logic addr_pin_low,       // Address select, bit 0.
  input wire logic addr_pin_high,      // Address select, bit 1.
  input wire logic load_strobe_n,      // Load strobe, active low.
  input wire logic gain_select_pin,    // High selects gain of two.
  output logic sda_out,                // Data drive value, always low.
  output logic sda_oe,                 // High while pulling data low.
  output logic [11:0] dac_code_a,      // Channel A DAC register.
  output logic [11:0] dac_code_b,      // Channel B DAC register.
  output logic output_gain_two,        // High when gain is two.
  output logic reference_enabled,      // High while reference is on.
  output logic [3:0] power_mode,       // {B[1:0], A[1:0]} power fields.
  output logic [1:0] strobe_mask       // {B, A} load strobe mask.
);
  import dac_cmd_pkg::*;

  // ==========================================================
  // Helpers.
  // ==========================================================

  // True when the select field of a word names the given channel.
  function automatic logic sel_hit(input logic [23:0] w, input int ch);
    sel_hit = (ch == 0) ? w[SEL_A_BIT] : w[SEL_B_BIT];
  endfunction

  // Extracts the channel code from a word; the low nibble is dropped.
  function automatic logic [11:0] code_of(input logic [23:0] w);
    code_of = w[CODE_MSB:CODE_LSB];
  endfunction

  // ==========================================================
  // Pin sampling.
  // ==========================================================
  logic [5:0] pins_sync; // Synchronised pin levels.
  logic scl_s;           // Synchronised serial clock.
  logic sda_s;           // Synchronised serial data.
  logic load_strobe_n_s;          // Synchronised load strobe, active low.
  logic gain_s;          // Synchronised gain select.
  logic [1:0] apin_s;    // Synchronised address pins.

  // Hundreds of samples per fast-mode SCL phase, so both bus speeds
  // work with no mode setting; idle reset levels avoid false edges.
  pin_sync #(.WIDTH(6), .RST_VAL(PIN_IDLE)) u_sync ( // see RULE_16
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .din({scl_in, sda_in, load_strobe_n, gain_select_pin,
          addr_pin_high, addr_pin_low}),
    .dout(pins_sync)
  );

  assign scl_s = pins_sync[5];
  assign sda_s = pins_sync[4];
  assign load_strobe_n_s = pins_sync[3];
  assign gain_s = pins_sync[2];
  assign apin_s = pins_sync[1:0];

  logic scl_d; // Serial clock one cycle ago.
  logic sda_d; // Serial data one cycle ago.

  // Delayed copies feed the edge and condition detectors.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic scl_rise; // Serial clock rising edge seen.
  logic scl_fall; // Serial clock falling edge seen.
  logic start_c;  // Data fell while clock high.
  logic stop_c;   // Data rose while clock high.
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // Bus receiver.
  // ==========================================================
  bus_state_t state;      // Receiver state.
  logic [2:0] bit_cnt;    // Bits taken in the current byte.
  logic [1:0] byte_idx;   // Data byte within the current word.
  logic have_bit;         // A bit was sampled at the last rise.
  logic bit_hold;         // Bit sampled at the last rise.
  logic [7:0] addr_byte;  // Address byte being assembled.
  logic [23:0] word;      // Input shift register.
  logic exec;             // One-cycle pulse: a whole word arrived.
  logic [7:0] next_addr;  // Address byte with the held bit added.
  logic addr_hit;         // Completed address names this slave.

  assign next_addr = {addr_byte[6:0], bit_hold};
  // Only 00011 plus the pin bits with write direction is taken, so
  // general call (all zero) and ten-bit prefixes never match.
  // Reads are not answered. (see RULE_18) (see RULE_17)
  assign addr_hit = (next_addr[7:3] == ADDR_FIXED) &&
                    (next_addr[2:1] == apin_s) && !next_addr[0];

  // SDA is sampled at SCL rise but shifted at the next fall, so a
  // start condition (also with SCL high) never counts as a data bit.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      bit_cnt <= 3'h0;
      byte_idx <= 2'h0;
      have_bit <= 1'b0;
      bit_hold <= 1'b0;
      addr_byte <= 8'h00;
      word <= RESET_WORD;
      exec <= 1'b0;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      exec <= 1'b0;
      if (start_c) begin
        // A start, repeated or not, always reopens address phase.
        state <= S_ADDR;
        bit_cnt <= 3'h0;
        byte_idx <= 2'h0;
        have_bit <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        // A stop drops any partial word. (see RULE_21)
        state <= S_IDLE;
        byte_idx <= 2'h0;
        have_bit <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        if (scl_rise) begin
          bit_hold <= sda_s;
          have_bit <= 1'b1;
        end
        if (scl_fall) begin
          have_bit <= 1'b0;
          unique case (state)
            S_IDLE: begin
              sda_oe <= 1'b0; // Not addressed: wait for a start.
            end
            S_ADDR: begin
              if (have_bit) begin
                addr_byte <= next_addr;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                  state <= addr_hit ? S_ADDR_ACK : S_IDLE;
                  sda_oe <= addr_hit;
                end
              end
            end
            S_ADDR_ACK: begin
              sda_oe <= 1'b0; // Release after the ninth clock.
              state <= S_DATA;
              byte_idx <= 2'h0;
              bit_cnt <= 3'h0;
            end
            S_DATA: begin
              if (have_bit) begin
                // MSB first into the 24-bit shifter. (see RULE_01)
                word <= {word[22:0], bit_hold}; // see RULE_05
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                  state <= S_DATA_ACK;
                  sda_oe <= 1'b1;
                end
              end
            end
            S_DATA_ACK: begin
              sda_oe <= 1'b0;
              state <= S_DATA;
              bit_cnt <= 3'h0;
              // Command, high, low bytes: the third ack ends the word.
              if (byte_idx == 2'(LAST_BYTE)) begin
                exec <= 1'b1; // see RULE_21
                byte_idx <= 2'h0;
              end else begin
                byte_idx <= byte_idx + 2'h1;
              end
            end
          endcase
        end
      end
    end
  end

  // The pin is open drain: only the enable moves.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // Command decoder and channel registers.
  // ==========================================================
  logic [3:0] cmd;             // Command field of the word.
  logic [11:0] code;           // Channel code of the word.
  logic [11:0] input_reg [2];  // Input registers, index 0 is A.
  logic [11:0] dac_reg [2];    // DAC registers, index 0 is A.
  logic [1:0] ld_active;       // Strobe low and channel unmasked.

  assign cmd = word[CMD_MSB:CMD_LSB]; // see RULE_02
  assign code = code_of(word); // see RULE_04 see RULE_12
  assign ld_active = {~load_strobe_n_s & ~strobe_mask[1], ~load_strobe_n_s & ~strobe_mask[0]};
  assign dac_code_a = dac_reg[0];
  assign dac_code_b = dac_reg[1];

  // Runs on the pulse after a full acknowledged word, so the word is
  // steady; a software reset matches the reset pin exactly.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int ch = 0; ch < 2; ch++) begin // see RULE_15
        input_reg[ch] <= RESET_CODE;
        dac_reg[ch] <= RESET_CODE;
      end
      power_mode <= RESET_POWER;
      strobe_mask <= RESET_MASK;
      reference_enabled <= 1'b1; // see RULE_14
    end else if (clk_en) begin
      // Input register is transparent while the strobe is low and the channel is unmasked.
      for (int ch = 0; ch < 2; ch++) begin
        if (ld_active[ch]) begin
          dac_reg[ch] <= input_reg[ch]; // see RULE_09
        end
      end
      if (exec) begin
        unique case (cmd) // Reserved codes reach default. see RULE_07
          CMD_NOP: begin
            // Nothing to do.
          end
          CMD_WRITE: begin
            for (int ch = 0; ch < 2; ch++) begin
              if (sel_hit(word, ch)) begin // see RULE_06 see RULE_03
                input_reg[ch] <= code; // see RULE_08
                if (ld_active[ch]) begin
                  dac_reg[ch] <= code; // see RULE_09
                end
              end
            end
          end
          CMD_UPDATE: begin
            for (int ch = 0; ch < 2; ch++) begin
              if (sel_hit(word, ch)) begin
                dac_reg[ch] <= input_reg[ch]; // see RULE_10
              end
            end
          end
          CMD_WRITE_UPDATE: begin
            for (int ch = 0; ch < 2; ch++) begin
              if (sel_hit(word, ch)) begin
                input_reg[ch] <= code; // see RULE_11
                dac_reg[ch] <= code;
              end
            end
          end
          CMD_POWER: begin
            power_mode <= {word[PWR_B_MSB:PWR_B_LSB],
                           word[PWR_A_MSB:PWR_A_LSB]};
          end
          CMD_MASK: begin
            strobe_mask <= {word[MASK_B_BIT], word[MASK_A_BIT]};
          end
          CMD_RESET: begin
            for (int ch = 0; ch < 2; ch++) begin
              input_reg[ch] <= RESET_CODE; // see RULE_07
              dac_reg[ch] <= RESET_CODE;
            end
            power_mode <= RESET_POWER;
            strobe_mask <= RESET_MASK;
            reference_enabled <= 1'b1;
          end
          CMD_REF: begin
            reference_enabled <= ~word[REF_OFF_BIT]; // see RULE_14
          end
          default: begin
            // Reserved codes leave everything alone. (see RULE_20)
          end
        endcase
      end
    end
  end

  // Gain follows the pin; it has no register of its own to program.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      output_gain_two <= 1'b0;
    end else if (clk_en) begin
      output_gain_two <= gain_s; // see RULE_13
    end
  end

  // ==========================================================
  // Checks.
  // ==========================================================
  a_addr_match: assert property (@(posedge clock) // see RULE_18
    disable iff (!resetn || !clk_en)
    (state == S_ADDR && scl_fall && have_bit && bit_cnt == 3'h7 &&
     !start_c && !stop_c && addr_hit) |=> (state == S_ADDR_ACK && sda_oe))
    else $error("addressed slave did not acknowledge");
  a_exec_after_ack: assert property (@(posedge clock) // see RULE_21
    disable iff (!resetn || !clk_en)
    exec |-> $past(state == S_DATA_ACK && sda_oe && byte_idx == 2'h2))
    else $error("word acted on without third acknowledge");
  a_write_input: assert property (@(posedge clock) // see RULE_08
    disable iff (!resetn || !clk_en)
    (exec && cmd == CMD_WRITE && word[SEL_A_BIT])
      |=> input_reg[0] == $past(code))
    else $error("input register A not loaded");
  a_write_update: assert property (@(posedge clock) // see RULE_11
    disable iff (!resetn || !clk_en)
    (exec && cmd == CMD_WRITE_UPDATE && word[SEL_B_BIT])
      |=> (dac_code_b == $past(code) && input_reg[1] == $past(code)))
    else $error("write and update on B failed");
  a_update_copy: assert property (@(posedge clock) // see RULE_10
    disable iff (!resetn || !clk_en)
    (exec && cmd == CMD_UPDATE && word[SEL_A_BIT])
      |=> dac_code_a == $past(input_reg[0]))
    else $error("update did not copy input register A");
  a_transparent_load: assert property (@(posedge clock) // see RULE_09
    disable iff (!resetn || !clk_en)
    (!load_strobe_n_s && !strobe_mask[0] && !exec)
      |=> dac_code_a == $past(input_reg[0]))
    else $error("strobe low did not pass input register A");
  a_soft_reset: assert property (@(posedge clock) // see RULE_07
    disable iff (!resetn || !clk_en)
    (exec && cmd == CMD_RESET) |=> (dac_code_a == RESET_CODE &&
      dac_code_b == RESET_CODE && reference_enabled && power_mode == 4'h0))
    else $error("software reset incomplete");
  a_reserved_quiet: assert property (@(posedge clock) // see RULE_20
    disable iff (!resetn || !clk_en)
    (exec && (cmd[3] || (cmd == CMD_WRITE_UPDATE &&
      !word[SEL_A_BIT] && !word[SEL_B_BIT])))
      |=> ($stable(input_reg[0]) && $stable(input_reg[1]) &&
           $stable(power_mode) && $stable(strobe_mask)))
    else $error("ignored command changed state");
  a_ref_only_sw: assert property (@(posedge clock) // see RULE_14
    disable iff (!resetn || !clk_en)
    $fell(reference_enabled) |-> $past(exec && cmd == CMD_REF))
    else $error("reference turned off without setup command");

endmodule

// >>> tb/i2c_master_model.sv
`timescale 1ns/1ps
// ============================================================
// Bus master model: drives the serial clock, pulls data low.
// ============================================================
module i2c_master_model (
  output logic scl,     // Serial clock, stands high between frames.
  output logic sda_low, // High while the master pulls data low.
  input wire logic sda  // Resolved data wire with its pull-up.
);
  // Both lines are released while the bus is idle.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One bit; data only moves while the clock is low.
  task automatic put_bit(input logic b);
    sda_low = !b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
    #40;
  endtask

  // One byte, then data is released for the slave's answer.
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 ack = !sda;
    #40 scl = 1'b0;
    #40;
  endtask

  // Start, address byte, then up to three bytes while acked, stop.
  task automatic send(input logic [7:0] ab, input logic [23:0] w,
                      input int n, output logic [2:0] acks);
    logic ack;
    sda_low = 1'b1;
    #80 scl = 1'b0;
    #40;
    put_byte(ab, ack);
    acks = {2'b00, ack};
    for (int i = 0; i < n; i++) begin
      if (ack) begin
        put_byte(w[23-8*i -: 8], ack);
        acks = acks + {2'b00, ack};
      end
    end
    // A stop: data rises while the clock is high.
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask
endmodule

// >>> tb/tb_dual_dac_i2c_command_decoder.sv
`timescale 1ns/1ps
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fails++; $display("wrong value %s expected %h seen %h", n, e, g); \
  end end
module tb_dual_dac_i2c_command_decoder;
  import dac_cmd_pkg::*;
  // ==========================================================
  // Signals.
  // ==========================================================
  localparam logic [7:0] OWN_W = {ADDR_FIXED, 2'b10, 1'b0}; // Our write.
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic load_strobe_n = 1'b1;
  logic gain_select_pin = 1'b0;
  logic scl, m_low, sda_oe, sda_out, output_gain_two, reference_enabled;
  logic [11:0] dac_code_a, dac_code_b;
  logic [3:0] power_mode;
  logic [1:0] strobe_mask;
  logic [2:0] acks;
  wire sda;
  int fails = 0;
  int tests_run = 0;

  // The data wire is pulled up unless either party pulls it low.
  assign sda = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  always #2 clock = ~clock;

  dual_dac_i2c_command_decoder dual_dac_i2c_command_decoder_i (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .scl_in(scl),
    .sda_in(sda), .addr_pin_low(1'b0), .addr_pin_high(1'b1),
    .load_strobe_n(load_strobe_n), .gain_select_pin(gain_select_pin),
    .sda_out(sda_out), .sda_oe(sda_oe), .dac_code_a(dac_code_a),
    .dac_code_b(dac_code_b), .output_gain_two(output_gain_two),
    .reference_enabled(reference_enabled), .power_mode(power_mode),
    .strobe_mask(strobe_mask));
  i2c_master_model i2c_master_model_i (.scl(scl), .sda_low(m_low),
    .sda(sda));

  // ==========================================================
  // Tasks.
  // ==========================================================
  // One frame, then the count of acknowledged bytes is compared.
  task automatic wr(input logic [7:0] ab, input logic [23:0] w,
                    input int n, input logic [2:0] exp_acks);
    i2c_master_model_i.send(ab, w, n, acks);
    repeat (8) @(negedge clock);
    `CHECK("acks", exp_acks, acks)
  endtask

  // Both converter registers against the expected codes.
  task automatic codes(input logic [11:0] a, input logic [11:0] b);
    `CHECK("dac_code_a", a, dac_code_a)
    `CHECK("dac_code_b", b, dac_code_b)
  endtask

  // Single place where the run ends.
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A hang is cut short well after the expected run of ~32k cycles.
  initial begin
    #250000;
    fails++;
    test_done();
  end

  // ==========================================================
  // Tests.
  // ==========================================================
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock) resetn = 1'b1;
    repeat (8) @(negedge clock);
    codes(12'h000, 12'h000);
    `CHECK("reference", 1'b1, reference_enabled)
    `CHECK("power", 4'h0, power_mode)
    // With the enable low the gain copy must not follow its pin.
    clk_en = 1'b0;
    gain_select_pin = 1'b1;
    repeat (8) @(negedge clock);
    `CHECK("frozen gain", 1'b0, output_gain_two)
    clk_en = 1'b1;
    repeat (8) @(negedge clock);
    `CHECK("gain", 1'b1, output_gain_two)
    gain_select_pin = 1'b0;
    wr(OWN_W, 24'h31_ABCF, 3, 3'h4);
    codes(12'hABC, 12'h000);
    wr(OWN_W, 24'h39_FFF0, 3, 3'h4);
    codes(12'hFFF, 12'hFFF);
    wr(OWN_W, 24'h18_1230, 3, 3'h4);
    codes(12'hFFF, 12'hFFF);
    wr(OWN_W, 24'h28_0000, 3, 3'h4);
    codes(12'hFFF, 12'h123);
    load_strobe_n = 1'b0;
    wr(OWN_W, 24'h11_4560, 3, 3'h4);
    codes(12'h456, 12'h123);
    wr(OWN_W, 24'h50_0001, 3, 3'h4);
    `CHECK("mask", 2'b01, strobe_mask)
    wr(OWN_W, 24'h11_7770, 3, 3'h4);
    codes(12'h456, 12'h123);
    load_strobe_n = 1'b1;
    for (int c = 8; c < 16; c++) begin
      wr(OWN_W, {c[3:0], 20'h9_5550}, 3, 3'h4);
      codes(12'h456, 12'h123);
    end
    wr(OWN_W, 24'h30_5550, 3, 3'h4);
    wr(OWN_W, 24'h31_5550, 2, 3'h3);
    codes(12'h456, 12'h123);
    wr(8'h1A, 24'h31_5550, 3, 3'h0);
    wr(8'h00, 24'h31_5550, 3, 3'h0);
    wr(OWN_W | 8'h01, 24'h31_5550, 3, 3'h0);
    codes(12'h456, 12'h123);
    wr(OWN_W, 24'h40_00C1, 3, 3'h4);
    `CHECK("power", 4'hD, power_mode)
    wr(OWN_W, 24'h70_0001, 3, 3'h4);
    `CHECK("reference", 1'b0, reference_enabled)
    wr(OWN_W, 24'h60_0000, 3, 3'h4);
    codes(12'h000, 12'h000);
    `CHECK("reference", 1'b1, reference_enabled)
    `CHECK("mask", 2'b00, strobe_mask)
    `CHECK("power", 4'h0, power_mode)
    test_done();
  end
endmodule
